// ### rtl/sct_timer_core.sv
// top of the single-channel timer core: registers, counter, capture and compare
// assumes an Avalon-MM master on the same clock and an asynchronous channel pin
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps

module sct_timer_core
   import sct_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        srst,
   // avalon-mm register slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // channel pins
   input  wire logic        chan_input,
   output logic             chan_output,
   output logic             chan_trigger,
   // interrupt
   output logic             irq
);

   // =====================================================================
   // state
   typedef struct packed {
      logic                      cpol;
      logic                      pol;
      logic                      en;
      logic                      dir_input;
      logic                      obuf;
      logic [15:0]               count;
      logic [15:0]               div;
      logic [15:0]               div_shadow;
      logic [15:0]               period;
      logic [15:0]               data;
      logic [15:0]               cmp_shadow;
      logic [SCT_NUM_EVENTS-1:0] status;
      logic [SCT_NUM_EVENTS-1:0] mask;
      logic                      waitreq;
      logic [31:0]               rdata;
      logic                      out;
      logic                      trig;
      logic                      irq;
   } sct_core_state_t;

   sct_core_state_t st;
   sct_core_state_t next_st;

   sct_core_if lnk ();

   // =====================================================================
   // helpers
   sct_prescaler u_prescaler (
      .clock (clock),
      .srst  (srst),
      .lnk   (lnk)
   );

   sct_edge_sync u_edge_sync (
      .clock      (clock),
      .srst       (srst),
      .chan_input (chan_input),
      .lnk        (lnk)
   );

   assign lnk.div     = st.div_shadow;
   assign lnk.restart = (st.period == SCT_RST_WORD16);

   // =====================================================================
   // byte-lane merge for 16-bit registers
   function automatic logic [15:0] sct_merge16(input logic [15:0] old_v,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
      logic [15:0] v;
      v = old_v;
      if (be[0]) begin
         v[7:0] = wd[7:0];
      end
      if (be[1]) begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction

   // =====================================================================
   // next-state logic
   always_comb begin
      logic                      wr_go;
      logic                      rd_go;
      logic                      running;
      logic                      overflow;
      logic [1:0]                edge_code;
      logic                      cap_hit;
      logic                      match;
      logic [15:0]               cmp;
      logic                      raw;
      logic [SCT_NUM_EVENTS-1:0] ev;
      logic [SCT_NUM_EVENTS-1:0] clr;

      next_st   = st;
      wr_go     = avs_write && !st.waitreq;
      rd_go     = avs_read && st.waitreq;
      running   = lnk.tick && (st.period != SCT_RST_WORD16);
      overflow  = running && (st.count >= st.period);
      edge_code = {st.cpol, st.pol};
      cap_hit   = 1'b0;
      match     = 1'b0;
      ev        = '0;
      clr       = '0;
      cmp       = SCT_RST_WORD16;
      raw       = 1'b0;

      // bus handshake: one wait cycle, then one cycle with waitrequest low
      next_st.waitreq = 1'b1;
      if ((avs_read || avs_write) && st.waitreq) begin
         next_st.waitreq = 1'b0;
      end

      // read data captured in the wait cycle, presented while waitrequest is low
      if (rd_go) begin
         next_st.rdata = SCT_RST_WORD32;
         if (avs_address == SCT_OFS_CHAN_CONTROL) begin
            next_st.rdata[SCT_BIT_CHAN_CPOL]   = st.cpol;
            next_st.rdata[SCT_BIT_CHAN_POL]    = st.pol;
            next_st.rdata[SCT_BIT_CHAN_ENABLE] = st.en;
         end else if (avs_address == SCT_OFS_COUNTER) begin
            next_st.rdata[15:0] = st.count;
         end else if (avs_address == SCT_OFS_PRESCALER) begin
            next_st.rdata[15:0] = st.div;
         end else if (avs_address == SCT_OFS_PERIOD) begin
            next_st.rdata[15:0] = st.period;
         end else if (avs_address == SCT_OFS_CHAN_DATA) begin
            next_st.rdata[15:0] = st.data;
         end else if (avs_address == SCT_OFS_STATUS) begin
            next_st.rdata[SCT_NUM_EVENTS-1:0] = st.status;
         end else if (avs_address == SCT_OFS_MASK) begin
            next_st.rdata[SCT_NUM_EVENTS-1:0] = st.mask;
         end else if (avs_address == SCT_OFS_CHAN_CONFIG) begin
            next_st.rdata[SCT_BIT_CFG_INPUT] = st.dir_input;
            next_st.rdata[SCT_BIT_CFG_OBUF]  = st.obuf;
         end
      end

      // register writes take effect on the acknowledge cycle
      if (wr_go) begin
         if (avs_address == SCT_OFS_CHAN_CONTROL) begin
            if (avs_byteenable[0]) begin
               next_st.cpol = avs_writedata[SCT_BIT_CHAN_CPOL];
               next_st.pol  = avs_writedata[SCT_BIT_CHAN_POL];
               next_st.en   = avs_writedata[SCT_BIT_CHAN_ENABLE];
            end
         end else if (avs_address == SCT_OFS_PRESCALER) begin
            next_st.div = sct_merge16(st.div, avs_writedata, avs_byteenable);
         end else if (avs_address == SCT_OFS_PERIOD) begin
            next_st.period = sct_merge16(st.period, avs_writedata, avs_byteenable);
         end else if (avs_address == SCT_OFS_CHAN_DATA) begin
            next_st.data = sct_merge16(st.data, avs_writedata, avs_byteenable);
         end else if (avs_address == SCT_OFS_STATUS) begin
            if (avs_byteenable[0]) begin
               clr = avs_writedata[SCT_NUM_EVENTS-1:0];
            end
         end else if (avs_address == SCT_OFS_MASK) begin
            if (avs_byteenable[0]) begin
               next_st.mask = avs_writedata[SCT_NUM_EVENTS-1:0];
            end
         end else if (avs_address == SCT_OFS_CHAN_CONFIG) begin
            if (avs_byteenable[0]) begin
               next_st.dir_input = avs_writedata[SCT_BIT_CFG_INPUT];
               next_st.obuf      = avs_writedata[SCT_BIT_CFG_OBUF];
            end
         end
      end

      // counter: software write wins over counting
      if (wr_go && (avs_address == SCT_OFS_COUNTER)) begin
         next_st.count = sct_merge16(st.count, avs_writedata, avs_byteenable);
      end else if (overflow) begin
         next_st.count = SCT_RST_WORD16;
      end else if (running) begin
         next_st.count = st.count + 16'h0001;
      end

      // shadows load at overflow
      if (overflow) begin
         next_st.div_shadow = next_st.div;
         next_st.cmp_shadow = next_st.data;
      end

      // input capture
      if (st.en && st.dir_input) begin
         case (edge_code)
            SCT_EDGE_RISE: cap_hit = lnk.rise;
            SCT_EDGE_FALL: cap_hit = lnk.fall;
            SCT_EDGE_BOTH: cap_hit = lnk.rise | lnk.fall;
            default:       cap_hit = 1'b0;
         endcase
      end
      if (cap_hit) begin
         next_st.data = st.count;
      end

      // trigger copy of the filtered input, inverted when falling-edge capture is selected
      next_st.trig = lnk.level ^ (edge_code == SCT_EDGE_FALL);

      // compare output
      cmp = st.obuf ? st.cmp_shadow : st.data;
      raw = (st.count < cmp);
      if (st.en && !st.dir_input) begin
         next_st.out = raw ^ st.pol;
         match       = running && (st.count == cmp);
      end else begin
         next_st.out = 1'b0;
      end

      // sticky events, a new event wins over a clear
      ev[SCT_BIT_ST_OVERFLOW] = overflow;
      ev[SCT_BIT_ST_CAPTURE]  = cap_hit;
      ev[SCT_BIT_ST_MATCH]    = match;
      next_st.status = (st.status & ~clr) | ev;
      next_st.irq    = |(next_st.status & next_st.mask);
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st         <= '0;
         st.waitreq <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // =====================================================================
   // outputs
   assign avs_readdata    = st.rdata;
   assign avs_waitrequest = st.waitreq;
   assign chan_output     = st.out;
   assign chan_trigger    = st.trig;
   assign irq             = st.irq;

endmodule // sct_timer_core

// ### rtl/sct_pkg.sv
// constants, register map and field layout of the single-channel timer core
// assumes a 40 MHz timer clock and a 32-bit Avalon-MM register slave

package sct_pkg;

   // =====================================================================
   // register byte offsets
   localparam logic [4:0] SCT_OFS_CHAN_CONTROL = 5'h00;
   localparam logic [4:0] SCT_OFS_COUNTER      = 5'h04;
   localparam logic [4:0] SCT_OFS_PRESCALER    = 5'h08;
   localparam logic [4:0] SCT_OFS_PERIOD       = 5'h0C;
   localparam logic [4:0] SCT_OFS_CHAN_DATA    = 5'h10;
   localparam logic [4:0] SCT_OFS_STATUS       = 5'h14;
   localparam logic [4:0] SCT_OFS_MASK         = 5'h18;
   localparam logic [4:0] SCT_OFS_CHAN_CONFIG  = 5'h1C;

   // =====================================================================
   // channel control fields
   localparam int SCT_BIT_CHAN_ENABLE = 0;
   localparam int SCT_BIT_CHAN_POL    = 1;
   localparam int SCT_BIT_CHAN_CPOL   = 3;
   // channel config fields
   localparam int SCT_BIT_CFG_INPUT   = 0;
   localparam int SCT_BIT_CFG_OBUF    = 1;
   // status and mask fields
   localparam int SCT_BIT_ST_OVERFLOW = 0;
   localparam int SCT_BIT_ST_CAPTURE  = 1;
   localparam int SCT_BIT_ST_MATCH    = 2;
   localparam int SCT_NUM_EVENTS      = 3;

   // =====================================================================
   // edge selection codes {cpol, pol}
   localparam logic [1:0] SCT_EDGE_RISE = 2'h0;
   localparam logic [1:0] SCT_EDGE_FALL = 2'h1;
   localparam logic [1:0] SCT_EDGE_RSVD = 2'h2;
   localparam logic [1:0] SCT_EDGE_BOTH = 2'h3;

   // =====================================================================
   // reset values
   localparam logic [15:0] SCT_RST_WORD16 = 16'h0000;
   localparam logic [31:0] SCT_RST_WORD32 = 32'h0000_0000;

endpackage : sct_pkg

// ### rtl/sct_core_if.sv
// links the timer core with its prescaler and input edge detector
// assumes all three modules run on the same clock
`timescale 1ns/10ps

interface sct_core_if;
   logic [15:0] div;
   logic        restart;
   logic        tick;
   logic        level;
   logic        rise;
   logic        fall;

   modport pre_mp  (input div, input restart, output tick);
   modport edge_mp (output level, output rise, output fall);
   modport core_mp (output div, output restart, input tick, input level, input rise, input fall);
endinterface : sct_core_if

// ### rtl/sct_prescaler.sv
// prescaler: one tick every div+1 clocks
// assumes div is held stable between overflow events by the core
`timescale 1ns/10ps

module sct_prescaler
   import sct_pkg::*;
(
   // clock and reset
   input  wire logic  clock,
   input  wire logic  srst,
   // core link
   sct_core_if.pre_mp lnk
);

   typedef struct packed {
      logic [15:0] cnt;
   } sct_pre_state_t;

   sct_pre_state_t st;
   sct_pre_state_t next_st;

   // =====================================================================
   // divider
   assign lnk.tick = (st.cnt == lnk.div) && !lnk.restart;

   always_comb begin
      next_st = st;
      if (lnk.restart || lnk.tick) begin
         next_st.cnt = SCT_RST_WORD16;
      end else begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // sct_prescaler

// ### rtl/sct_edge_sync.sv
// channel pin synchroniser and edge detector
// assumes the pin is asynchronous to the clock
`timescale 1ns/10ps

module sct_edge_sync
   import sct_pkg::*;
(
   // clock and reset
   input  wire logic   clock,
   input  wire logic   srst,
   // channel pin
   input  wire logic   chan_input,
   // core link
   sct_core_if.edge_mp lnk
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic prev;
   } sct_edge_state_t;

   sct_edge_state_t st;
   sct_edge_state_t next_st;

   // =====================================================================
   // three-stage sync, level moves once stages two and three agree
   assign lnk.level = st.level;
   assign lnk.rise  = st.level & ~st.prev;
   assign lnk.fall  = ~st.level & st.prev;

   always_comb begin
      next_st      = st;
      next_st.s1   = chan_input;
      next_st.s2   = st.s1;
      next_st.s3   = st.s2;
      next_st.prev = st.level;
      if (st.s2 == st.s3) begin
         next_st.level = st.s3;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // sct_edge_sync

// ### sim/sct_pin_model.sv
// far side of the channel pin: an external source that drives the pin level
// assumes the bench asks for a level right after a clock edge; the pin moves later, off the edge
`timescale 1ns/10ps

module sct_pin_model #(
   parameter int LAG_NS = 7
) (
   // request from the bench
   input  wire logic want_lvl,
   // channel pin
   output logic      chan_input
);
   // pin is asynchronous to the timer clock, so it never moves on an edge
   initial chan_input = 1'b0;
   always @(want_lvl) chan_input <= #(LAG_NS) want_lvl;
endmodule // sct_pin_model

// ### sim/sct_timer_core_assertions.sv
// concurrent checks on the timer core ports, bound into sct_timer_core
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps

module sct_timer_core_assertions
   import sct_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        srst,
   // register bus
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // pins and interrupt
   input wire logic        chan_input,
   input wire logic        chan_output,
   input wire logic        chan_trigger,
   input wire logic        irq
);
   // =====================================================================
   // shadow of the control, config and mask registers seen on the bus
   logic [3:0] ctl_q;
   logic       in_mode;
   logic [2:0] mask_q;
   logic       acc_wr;
   logic       req;
   logic       out_off;
   logic [1:0] edge_code;
   assign acc_wr    = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign req       = avs_read || avs_write;
   assign out_off   = !ctl_q[0] || in_mode;
   assign edge_code = {ctl_q[3], ctl_q[1]};
   always_ff @(posedge clock) begin
      if (srst) begin
         ctl_q   <= 4'h0;
         in_mode <= 1'b0;
         mask_q  <= 3'h0;
      end else if (acc_wr) begin
         if (avs_address == SCT_OFS_CHAN_CONTROL) ctl_q <= {avs_writedata[3], 1'b0, avs_writedata[1:0]};
         if (avs_address == SCT_OFS_CHAN_CONFIG) in_mode <= avs_writedata[0];
         if (avs_address == SCT_OFS_MASK) mask_q <= avs_writedata[2:0];
      end
   end

   // =====================================================================
   // properties
   default clocking @(posedge clock); endclocking
   default disable iff (srst);

   a_wait_accept: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not low one cycle after request");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(req))
      else $error("waitrequest fell with no request");
   a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_ctl_readback: assert property (avs_read && !avs_waitrequest && avs_address == SCT_OFS_CHAN_CONTROL
      |-> avs_readdata[15:0] == {12'h000, ctl_q}) else $error("control readback wrong");
   a_out_off: assert property (out_off && $past(out_off) |-> !chan_output)
      else $error("channel output high while disabled");
   a_trig_polarity: assert property (($stable(chan_input) && $stable(ctl_q))[*8]
      |-> chan_trigger == (chan_input ^ (edge_code == SCT_EDGE_FALL))) else $error("trigger polarity wrong");
   a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
      else $error("interrupt high while all masked");
endmodule // sct_timer_core_assertions

bind sct_timer_core sct_timer_core_assertions u_sct_timer_core_assertions (
   .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .chan_input(chan_input), .chan_output(chan_output),
   .chan_trigger(chan_trigger), .irq(irq));

// ### sim/sct_timer_core_tb.sv
// self-checking bench of the timer core: register tasks and directed tests
// assumes sct_pin_model drives the channel pin and the checker is bound in
`timescale 1ns/10ps

module sct_timer_core_tb
   import sct_pkg::*;
;
   logic        clock;
   logic        srst;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        chan_input;
   logic        chan_output;
   logic        chan_trigger;
   logic        irq;
   logic        want_lvl;
   logic [31:0] rv;
   logic [31:0] v1;
   int          bad_count;
   int          n_tests;
   // {capture on rise, capture on fall, control}
   logic [5:0]  cap_tab [5] = '{6'h21, 6'h13, 6'h3B, 6'h09, 6'h00};
   // {expected output, control} against compare value
   logic [4:0]  cmp_tab [5] = '{5'h11, 5'h03, 5'h00, 5'h01, 5'h13};
   logic [15:0] cmp_val [5] = '{16'h000A, 16'h000A, 16'h000A, 16'h0003, 16'h0003};

   sct_timer_core u_sct_timer_core (
      .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .chan_input(chan_input), .chan_output(chan_output),
      .chan_trigger(chan_trigger), .irq(irq));
   sct_pin_model u_sct_pin_model (.want_lvl(want_lvl), .chan_input(chan_input));

   // =====================================================================
   // tasks
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rv = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      repeat (4000) @(posedge clock);
      bad_count++;
      give_verdict();
   end

   // =====================================================================
   // tests
   initial begin
      {srst, avs_address, avs_read, avs_write, avs_writedata, want_lvl} = {1'b1, 40'h0};
      avs_byteenable = 4'h3;
      bad_count = 0;
      n_tests   = 0;
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 5'(4 * i), 32'h0);
         chk("reset value", rv, 32'h0);
      end
      bus(1'b0, 5'h1F, 32'h0);
      chk("unmapped", rv, 32'h0);
      bus(1'b1, SCT_OFS_CHAN_CONTROL, 32'h0000_000F);
      bus(1'b0, SCT_OFS_CHAN_CONTROL, 32'h0);
      chk("control", rv, 32'h0000_000B);
      bus(1'b1, SCT_OFS_CHAN_CONTROL, 32'h0);
      $display("test registers done");
      bus(1'b1, SCT_OFS_COUNTER, 32'h1234);
      repeat (6) @(posedge clock);
      bus(1'b0, SCT_OFS_COUNTER, 32'h0);
      chk("held count", rv, 32'h1234);
      bus(1'b1, SCT_OFS_PERIOD, 32'h5);
      bus(1'b1, SCT_OFS_COUNTER, 32'h0);
      bus(1'b0, SCT_OFS_COUNTER, 32'h0);
      v1 = rv;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, SCT_OFS_COUNTER, 32'h0);
         chk("wrap", rv, (v1 + 32'h3) % 32'h6);
         v1 = rv;
      end
      bus(1'b0, SCT_OFS_STATUS, 32'h0);
      chk("overflow flag", rv[0], 32'h1);
      bus(1'b1, SCT_OFS_PERIOD, 32'h0);
      chk("irq masked", irq, 32'h0);
      bus(1'b1, SCT_OFS_MASK, 32'h1);
      @(posedge clock);
      chk("irq raised", irq, 32'h1);
      bus(1'b1, SCT_OFS_STATUS, 32'h1);
      @(posedge clock);
      chk("irq cleared", irq, 32'h0);
      $display("test count and interrupt done");
      bus(1'b1, SCT_OFS_PERIOD, 32'hFFFF);
      bus(1'b1, SCT_OFS_PRESCALER, 32'h2);
      bus(1'b0, SCT_OFS_COUNTER, 32'h0);
      v1 = rv;
      bus(1'b0, SCT_OFS_COUNTER, 32'h0);
      chk("old divide", rv, v1 + 32'h3);
      bus(1'b1, SCT_OFS_COUNTER, 32'hFFF0);
      repeat (30) @(posedge clock);
      bus(1'b0, SCT_OFS_COUNTER, 32'h0);
      v1 = rv;
      bus(1'b0, SCT_OFS_COUNTER, 32'h0);
      chk("new divide", rv, v1 + 32'h1);
      bus(1'b1, SCT_OFS_PERIOD, 32'h0);
      bus(1'b1, SCT_OFS_PRESCALER, 32'h0);
      $display("test prescaler done");
      bus(1'b1, SCT_OFS_CHAN_CONFIG, 32'h1);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, SCT_OFS_CHAN_CONTROL, {28'h0, cap_tab[i][3:0]});
         bus(1'b1, SCT_OFS_CHAN_DATA, 32'h0);
         bus(1'b1, SCT_OFS_COUNTER, 32'h100 + i);
         want_lvl <= 1'b1;
         repeat (8) @(posedge clock);
         bus(1'b0, SCT_OFS_CHAN_DATA, 32'h0);
         chk("rise capture", rv, cap_tab[i][5] ? 32'h100 + i : 32'h0);
         bus(1'b1, SCT_OFS_COUNTER, 32'h200 + i);
         want_lvl <= 1'b0;
         repeat (8) @(posedge clock);
         bus(1'b0, SCT_OFS_CHAN_DATA, 32'h0);
         chk("fall capture", rv, cap_tab[i][4] ? 32'h200 + i : (cap_tab[i][5] ? 32'h100 + i : 32'h0));
         chk("trigger", chan_trigger, {cap_tab[i][3], cap_tab[i][1]} == SCT_EDGE_FALL);
      end
      bus(1'b0, SCT_OFS_STATUS, 32'h0);
      chk("capture flag", rv[SCT_BIT_ST_CAPTURE], 32'h1);
      $display("test capture done");
      bus(1'b1, SCT_OFS_CHAN_CONFIG, 32'h0);
      bus(1'b1, SCT_OFS_COUNTER, 32'h5);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, SCT_OFS_CHAN_DATA, {16'h0, cmp_val[i]});
         bus(1'b1, SCT_OFS_CHAN_CONTROL, {28'h0, cmp_tab[i][3:0]});
         @(posedge clock);
         chk("compare output", chan_output, cmp_tab[i][4]);
      end
      bus(1'b1, SCT_OFS_CHAN_CONFIG, 32'h2);
      bus(1'b1, SCT_OFS_CHAN_CONTROL, 32'h1);
      bus(1'b1, SCT_OFS_CHAN_DATA, 32'hA);
      @(posedge clock);
      chk("buffered compare", chan_output, 32'h0);
      bus(1'b1, SCT_OFS_PERIOD, 32'h7);
      repeat (20) @(posedge clock);
      chk("loaded compare", chan_output, 32'h1);
      bus(1'b1, SCT_OFS_CHAN_DATA, 32'h3);
      repeat (20) @(posedge clock);
      bus(1'b0, SCT_OFS_STATUS, 32'h0);
      chk("match flag", rv[SCT_BIT_ST_MATCH], 32'h1);
      $display("test compare done");
      give_verdict();
   end
endmodule // sct_timer_core_tb
